/* sim/ahb_master_model.sv */
module ahb_master_model (
   input  wire logic               hclk,
   input  wire logic               hreadyout,
   input  wire logic [31:0]        hrdata,
   output logic                    hsel,
   output logic [31:0]             haddr,
   output logic [1:0]              htrans,
   output logic                    hwrite,
   output logic [2:0]              hsize,
   output logic [31:0]             hwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import alu_pkg::*;

   // ==========================================================================
   // Bus master, one whole-word transfer at a time
   // ==========================================================================
   // Quiet bus at time zero
   initial begin
      hsel   = 1'b0;
      htrans = 2'b00;
      haddr  = 32'h0000_0000;
      hwrite = 1'b0;
      hsize  = SIZE_WORD;
      hwdata = 32'h0000_0000;
   end

   // Each phase held until hready is seen high; bounded so a hang ends
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic ok);
      int n;
      n = 0;
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {20'h00000, a};
      hwrite <= w;
      hsize  <= SIZE_WORD;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 80);
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= wd;
      haddr  <= ~haddr;   // Address no longer qualified, so scramble it
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 80);
      rd = hrdata;
      ok = (hreadyout === 1'b1);
      hwdata <= ~wd;      // Released data must not look still valid
   endtask
endmodule // ahb_master_model

/* sim/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import alu_pkg::*;

   // ==========================================================================
   // Signals and bench state
   // ==========================================================================
   typedef struct packed {
      logic [31:0] insn;
      logic [31:0] d;
      logic [31:0] s;
      logic [31:0] exp_d;
      logic [4:0]  psw0;
      logic [4:0]  exp_psw;
   } row_t;

   localparam logic [11:0] A_D = OFF_GPR_BASE + 12'h008;   // Destination is r2
   localparam logic [11:0] A_S = OFF_GPR_BASE + 12'h00c;   // Source is r3

   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   logic [31:0] rv;
   logic        ok;
   logic [4:0]  f;
   int          n_mismatch = 0;
   int          compares = 0;

   function automatic logic [31:0] mk(input logic [15:0] hi, input logic [5:0] opc, input logic [4:0] lo);
      return {hi, 5'd2, opc, lo};
   endfunction

   // Condition table: z=0 s=1 ov=2 cy=3 sat=4; 4'hd tests the sticky flag
   function automatic logic cond(input logic [3:0] c, input logic [4:0] p);
      logic r;
      case (c[2:0])
         3'h0: r = p[2];
         3'h1: r = p[3];
         3'h2: r = p[0];
         3'h3: r = p[3] | p[0];
         3'h4: r = p[1];
         3'h5: r = 1'b1;
         3'h6: r = p[1] ^ p[2];
         default: r = (p[1] ^ p[2]) | p[0];
      endcase
      if (c == 4'hd) return p[4];
      return r ^ c[3];
   endfunction

   // Destination, r0 never, per row: insn, d, s, expected d, psw before, psw after
   localparam row_t rows [10] = '{
      '{mk(EXT_SAR, OPC_SAR_REG, 5'd3), 32'h8000_0018, 32'hffff_ffe4, 32'hf800_0001, 5'h14, 5'h1a},
      '{mk(16'h0, OPC_SAR_IMM, 5'd0), 32'h1234_5678, 32'h0, 32'h1234_5678, 5'h0f, 5'h00},
      '{mk(16'h0, OPC_SAR_IMM, 5'd31), 32'h4000_0000, 32'h0, 32'h0, 5'h00, 5'h09},
      '{mk(16'h0, OPC_ADD_REG, 5'd3), 32'h7fff_fff0, 32'h20, 32'h7fff_ffff, 5'h00, 5'h14},
      '{mk(16'h0, OPC_ADD_IMM, 5'h1f), 32'h1, 32'h0, 32'h0, 5'h10, 5'h19},
      '{mk(16'h0, OPC_ADD_REG, 5'd3), 32'h8000_0000, 32'hffff_ffff, 32'h8000_0000, 5'h00, 5'h1e},
      '{mk(16'h0, OPC_SUB_REG, 5'd3), 32'h8000_0000, 32'h1, 32'h8000_0000, 5'h00, 5'h16},
      '{mk(16'h0, OPC_SUB_REG, 5'd3), 32'h5, 32'h7, 32'hffff_fffe, 5'h10, 5'h1a},
      '{mk(16'h8000, OPC_SUBI, 5'd3), 32'h55, 32'h7fff_fffe, 32'h7fff_ffff, 5'h00, 5'h1c},
      '{mk(16'h0010, OPC_SUBI, 5'd3), 32'h55, 32'h10, 32'h0, 5'h00, 5'h01}
   };

   // ==========================================================================
   // Clock, design and master
   // ==========================================================================
   // Free-running 4 ns clock
   always #2 hclk = ~hclk;

   shift_saturate_alu u_shift_saturate_alu (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hreadyout),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata)
   );

   ahb_master_model u_ahb_master_model (
      .hclk      (hclk),
      .hreadyout (hreadyout),
      .hrdata    (hrdata),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata)
   );

   // ==========================================================================
   // Checking and bus helpers
   // ==========================================================================
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("mismatches=%0d compares=%0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // A stalled bus counts against the run and ends it
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      u_ahb_master_model.xfer(w, a, d, rv, ok);
      if (!ok) begin
         n_mismatch++;
         close_out();
      end
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rv, exp);
   endtask

   // ==========================================================================
   // Sequence
   // ==========================================================================
   // Hang guard well beyond the longest legal run
   initial begin
      repeat (100000) @(posedge hclk);
      n_mismatch++;
      close_out();
   end

   // Rows first, then condition sweep, back-to-back and reset cases
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rchk(OFF_PSW, 32'h0);
      foreach (rows[i]) begin
         bus(1'b1, A_D, rows[i].d);
         bus(1'b1, A_S, rows[i].s);
         bus(1'b1, OFF_PSW, {27'h0, rows[i].psw0});
         bus(1'b1, OFF_INSN, rows[i].insn);
         rchk(A_D, rows[i].exp_d);
         rchk(A_S, rows[i].s);
         rchk(OFF_PSW, {27'h0, rows[i].exp_psw});
      end
      for (int c = 0; c < 16; c++) begin
         f = 5'(c * 7);
         bus(1'b1, A_D, 32'h8000_0002);
         bus(1'b1, OFF_PSW, {27'h0, f});
         bus(1'b1, OFF_INSN, {EXT_SHIFT_IN_CONDITION, 5'd2, OPC_SHIFT_IN_CONDITION, 4'(c)});
         rchk(A_D, {31'h2, cond(4'(c), f)});
         rchk(OFF_PSW, {27'h0, f});
      end
      // Second instruction must see the first one's carry at once
      bus(1'b1, A_D, 32'h3);
      bus(1'b1, OFF_PSW, 32'h0);
      bus(1'b1, OFF_INSN, mk(16'h0, OPC_SAR_IMM, 5'd1));
      bus(1'b1, OFF_INSN, {EXT_SHIFT_IN_CONDITION, 5'd2, OPC_SHIFT_IN_CONDITION, 4'h1});
      rchk(A_D, 32'h3);
      rchk(OFF_PSW, 32'h8);
      rchk(OFF_STATUS, 32'h0000_0020);
      // Right first halfword, wrong second: must start nothing
      bus(1'b1, OFF_INSN, mk(16'h0001, OPC_SAR_REG, 5'd3));
      rchk(OFF_STATUS, 32'h0000_0001);
      rchk(A_D, 32'h3);
      rchk(OFF_PSW, 32'h8);
      // Zero register ignores writes and reads back zero
      bus(1'b1, OFF_GPR_BASE, 32'hffff_ffff);
      rchk(OFF_GPR_BASE, 32'h0);
      bus(1'b1, OFF_PSW, 32'h1f);
      bus(1'b1, OFF_PSW, 32'h0f);
      rchk(OFF_PSW, 32'h0f);
      bus(1'b1, OFF_PSW, 32'h1f);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      // Bus outputs while reset is held
      check(hrdata, 32'h0);
      check({31'h0, hreadyout}, 32'h1);
      check({31'h0, hresp}, 32'h0);
      hresetn <= 1'b1;
      @(posedge hclk);
      rchk(OFF_PSW, 32'h0);
      rchk(OFF_STATUS, 32'h0);
      close_out();
   end
endmodule // tb

/* verilog/alu_pkg.sv */
package alu_pkg;

   // ==========================================================================
   // Register map (byte addresses, low 12 bits of haddr)
   // ==========================================================================
   localparam logic [11:0] OFF_INSN     = 12'h000;   // Instruction word, write starts execution
   localparam logic [11:0] OFF_STATUS   = 12'h004;   // Decode status, read only
   localparam logic [11:0] OFF_PSW      = 12'h008;   // Condition flags
   localparam logic [11:0] OFF_GPR_BASE = 12'h100;   // 32 general registers, one word each
   localparam logic [4:0]  GPR_WIN_TAG  = 5'h02;     // haddr[11:7] of the register window
   localparam logic [2:0]  SIZE_WORD    = 3'h2;
   localparam logic [4:0]  ZERO_REG     = 5'h00;

   // ==========================================================================
   // Field layout and reset values
   // ==========================================================================
   localparam int unsigned PSW_W           = 5;      // z=0 s=1 ov=2 cy=3 sat=4
   localparam logic [4:0]  PSW_RESET       = 5'h00;
   localparam int unsigned STAT_ILLEGAL    = 0;
   localparam int unsigned STAT_OP_LSB     = 4;
   localparam logic [31:0] INSN_RESET      = 32'h0000_0000;
   localparam logic [31:0] SAT_MAX         = 32'h7fff_ffff;
   localparam logic [31:0] SAT_MIN         = 32'h8000_0000;

   // ==========================================================================
   // Opcode fields
   // ==========================================================================
   localparam logic [5:0]  OPC_SAR_REG  = 6'h3f;     // bits 10:5
   localparam logic [5:0]  OPC_SAR_IMM  = 6'h15;
   localparam logic [5:0]  OPC_ADD_REG  = 6'h06;
   localparam logic [5:0]  OPC_ADD_IMM  = 6'h11;
   localparam logic [5:0]  OPC_SUB_REG  = 6'h05;
   localparam logic [5:0]  OPC_SUBI     = 6'h33;
   localparam logic [6:0]  OPC_SHIFT_IN_CONDITION     = 7'h7e;     // bits 10:4
   localparam logic [15:0] EXT_SAR      = 16'h00a0;  // second halfword
   localparam logic [15:0] EXT_SHIFT_IN_CONDITION     = 16'h0200;

   // ==========================================================================
   // Condition codes, low three bits select, bit 3 inverts except in CC_SA
   // ==========================================================================
   localparam logic [2:0]  CC_OV = 3'h0;
   localparam logic [2:0]  CC_CY = 3'h1;
   localparam logic [2:0]  CC_Z  = 3'h2;
   localparam logic [2:0]  CC_NH = 3'h3;
   localparam logic [2:0]  CC_S  = 3'h4;
   localparam logic [2:0]  CC_T  = 3'h5;
   localparam logic [2:0]  CC_LT = 3'h6;
   localparam logic [2:0]  CC_LE = 3'h7;
   localparam logic [3:0]  CC_SA = 4'hd;             // Not the inverse of always

   // ==========================================================================
   // Types
   // ==========================================================================
   typedef struct packed {
      logic clamp_sticky_flag;
      logic cy;
      logic ov;
      logic s;
      logic z;
   } flags_t;

   typedef enum logic [2:0] {OP_NONE, OP_SAR, OP_SHIFT_IN_CONDITION, OP_ADD, OP_SUB, OP_SUBI} op_t;

   typedef enum logic [2:0] {S_IDLE, S_RD_DST, S_RD_SRC, S_EXEC, S_GPR, S_RESP} fsm_t;

   typedef struct packed {
      logic        en;
      logic [4:0]  addr;
      logic [31:0] data;
   } gpr_wr_t;

   typedef struct packed {
      fsm_t        fsm;
      logic        dph;      // Data phase pending
      logic        dwr;
      logic        dok;      // Whole-word access
      logic [11:0] daddr;
      logic [31:0] insn;
      op_t         op;
      logic        illegal;
      flags_t      flags;
      logic [31:0] opa;      // Destination operand
      logic        rd_zero;  // Last read was the zero register
      logic [31:0] rdata;
   } alu_st_t;

endpackage

/* verilog/gpr_mem.sv */
module gpr_mem (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             rd_en,
   input  wire logic [4:0]       rd_addr,
   input  wire alu_pkg::gpr_wr_t wr,
   output logic [31:0]           rd_data
);
   import alu_pkg::*;

   logic [31:0] mem_ff [0:31];
   logic [31:0] rd_data_ff;

   // ==========================================================================
   // Storage, no reset: contents are undefined until software loads them
   // ==========================================================================
   always_ff @(posedge hclk) begin
      if (wr.en) begin
         mem_ff[wr.addr] <= wr.data;
      end
   end

   // Registered read, old data on a same-address write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_data_ff <= 32'h0000_0000;
      end else if (rd_en) begin
         rd_data_ff <= mem_ff[rd_addr];
      end
   end

   assign rd_data = rd_data_ff;

endmodule // gpr_mem

/* verilog/shift_saturate_alu.sv */
module shift_saturate_alu (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata
);
   import alu_pkg::*;

   alu_st_t     st_ff;
   alu_st_t     nxt_st;
   logic        rd_en;
   logic [4:0]  rd_addr;
   gpr_wr_t     wr;
   logic [31:0] rd_data;
   logic [31:0] rd_val;
   logic        accept;
   logic        psw_load;
   logic        in_exec;
   logic [4:0]  dst_idx;
   logic [4:0]  src_idx;
   logic [31:0] dst_v;
   logic [31:0] src_v;
   logic [4:0]  cnt;
   logic        sar_imm;
   logic        add_imm;
   logic [31:0] sar_res;
   logic        sar_cy;
   logic [31:0] ex_a;
   logic [31:0] ex_b;
   logic [32:0] sum33;
   logic [32:0] diff33;
   logic        is_sub;
   logic [32:0] raw33;
   logic        ex_ov;
   logic [31:0] clamp_res;
   logic [31:0] ex_res;
   flags_t      ex_flags;
   logic        cond_ok;

   // ==========================================================================
   // Decode and condition evaluation
   // ==========================================================================
   // Register shift and condition shift share bits 10:5, so the second
   // halfword must be checked before the first-halfword-only patterns
   function automatic op_t decode_op(input logic [31:0] w);
      op_t r;
      r = OP_NONE;
      if (w[10:5] == OPC_SAR_REG && w[31:16] == EXT_SAR) begin
         r = OP_SAR;
      end else if (w[10:4] == OPC_SHIFT_IN_CONDITION && w[31:16] == EXT_SHIFT_IN_CONDITION) begin
         r = OP_SHIFT_IN_CONDITION;
      end else if (w[10:5] == OPC_SAR_IMM) begin
         r = OP_SAR;
      end else if (w[10:5] == OPC_ADD_REG || w[10:5] == OPC_ADD_IMM) begin
         r = OP_ADD;
      end else if (w[10:5] == OPC_SUB_REG) begin
         r = OP_SUB;
      end else if (w[10:5] == OPC_SUBI) begin
         r = OP_SUBI;
      end
      return r;
   endfunction

   // Shared four-bit condition decode
   function automatic logic cond_hold(input logic [3:0] cc, input flags_t f);
      logic b;
      b = 1'b0;
      case (cc[2:0])
         CC_OV:   b = f.ov;
         CC_CY:   b = f.cy;
         CC_Z:    b = f.z;
         CC_NH:   b = f.cy | f.z;
         CC_S:    b = f.s;
         CC_T:    b = 1'b1;
         CC_LT:   b = f.s ^ f.ov;
         CC_LE:   b = (f.s ^ f.ov) | f.z;
         default: b = 1'b0;
      endcase
      if (cc == CC_SA) begin
         return f.clamp_sticky_flag;
      end
      return b ^ cc[3];
   endfunction

   // ==========================================================================
   // Register file
   // ==========================================================================
   gpr_mem u_gpr (
      .hclk    (hclk),
      .hresetn (hresetn),
      .rd_en   (rd_en),
      .rd_addr (rd_addr),
      .wr      (wr),
      .rd_data (rd_data)
   );

   // ==========================================================================
   // Execute datapath
   // ==========================================================================
   // Zero register reads as zero without ever being written
   assign rd_val  = st_ff.rd_zero ? 32'h0000_0000 : rd_data;
   assign in_exec = (st_ff.fsm == S_EXEC);
   assign dst_idx = st_ff.insn[15:11];
   assign src_idx = st_ff.insn[4:0];
   assign dst_v   = st_ff.opa;
   assign src_v   = rd_val;
   assign sar_imm = (st_ff.insn[10:5] == OPC_SAR_IMM);
   assign add_imm = (st_ff.insn[10:5] == OPC_ADD_IMM);

   // Shift count, source register left untouched
   assign cnt     = sar_imm ? st_ff.insn[4:0] : src_v[4:0];
   assign sar_res = 32'($signed(dst_v) >>> cnt);
   assign sar_cy  = (cnt != 5'h00) && dst_v[5'(cnt - 5'h01)];

   // One adder pair serves all three clamping forms
   assign is_sub = (st_ff.op == OP_SUB) || (st_ff.op == OP_SUBI);
   assign ex_a   = (st_ff.op == OP_SUBI) ? src_v : dst_v;
   always_comb begin
      if (st_ff.op == OP_SUBI) begin
         ex_b = {{16{st_ff.insn[31]}}, st_ff.insn[31:16]};
      end else if (st_ff.op == OP_ADD && add_imm) begin
         ex_b = {{27{st_ff.insn[4]}}, st_ff.insn[4:0]};
      end else begin
         ex_b = src_v;
      end
   end
   assign sum33  = {1'b0, ex_a} + {1'b0, ex_b};
   assign diff33 = {1'b0, ex_a} - {1'b0, ex_b};
   assign raw33  = is_sub ? diff33 : sum33;
   assign ex_ov  = is_sub ? ((ex_a[31] != ex_b[31]) && (diff33[31] != ex_a[31]))
                          : ((ex_a[31] == ex_b[31]) && (sum33[31] != ex_a[31]));
   // Overflow direction follows the sign of the first operand
   assign clamp_res = ex_ov ? (ex_a[31] ? SAT_MIN : SAT_MAX) : raw33[31:0];
   assign cond_ok   = cond_hold(st_ff.insn[3:0], st_ff.flags);

   // Result and flag selection per operation
   always_comb begin
      ex_res   = dst_v;
      ex_flags = st_ff.flags;
      case (st_ff.op)
         OP_SAR: begin
            ex_res      = sar_res;
            ex_flags.cy = sar_cy;
            ex_flags.ov = 1'b0;
            ex_flags.s  = sar_res[31];
            ex_flags.z  = (sar_res == 32'h0000_0000);
         end
         OP_SHIFT_IN_CONDITION: begin
            ex_res = {dst_v[30:0], cond_ok};
         end
         OP_ADD, OP_SUB, OP_SUBI: begin
            // Sticky flag only ever ORs in, whatever its prior value
            ex_res       = clamp_res;
            ex_flags.cy  = raw33[32];
            ex_flags.ov  = ex_ov;
            ex_flags.s   = clamp_res[31];
            ex_flags.z   = (clamp_res == 32'h0000_0000);
            ex_flags.clamp_sticky_flag = st_ff.flags.clamp_sticky_flag | ex_ov;
         end
         default: begin
            ex_res   = dst_v;
            ex_flags = st_ff.flags;
         end
      endcase
   end

   // ==========================================================================
   // Bus slave and sequencing
   // ==========================================================================
   assign accept = hsel && htrans[1] && hready;

   // Data phases wait while an instruction runs, so a flag-word load can
   // never collide with a write-back
   always_comb begin
      nxt_st    = st_ff;
      rd_en     = 1'b0;
      rd_addr   = ZERO_REG;
      wr        = '0;
      psw_load  = 1'b0;
      hreadyout = !st_ff.dph || (st_ff.fsm == S_RESP) || (st_ff.fsm == S_IDLE && st_ff.dwr);
      case (st_ff.fsm)
         S_IDLE: begin
            if (st_ff.dph && st_ff.dwr && st_ff.dok) begin
               if (st_ff.daddr == OFF_INSN) begin
                  nxt_st.insn    = hwdata;
                  nxt_st.op      = decode_op(hwdata);
                  nxt_st.illegal = (decode_op(hwdata) == OP_NONE);
                  if (decode_op(hwdata) != OP_NONE) begin
                     nxt_st.fsm = S_RD_DST;
                  end
               end else if (st_ff.daddr == OFF_PSW) begin
                  nxt_st.flags = flags_t'(hwdata[PSW_W-1:0]);
                  psw_load     = 1'b1;
               end else if (st_ff.daddr[11:7] == GPR_WIN_TAG && st_ff.daddr[6:2] != ZERO_REG) begin
                  wr.en   = 1'b1;
                  wr.addr = st_ff.daddr[6:2];
                  wr.data = hwdata;
               end
            end else if (st_ff.dph && !st_ff.dwr) begin
               nxt_st.fsm   = S_RESP;
               nxt_st.rdata = 32'h0000_0000;
               if (st_ff.daddr == OFF_INSN) begin
                  nxt_st.rdata = st_ff.insn;
               end else if (st_ff.daddr == OFF_STATUS) begin
                  nxt_st.rdata[STAT_ILLEGAL]            = st_ff.illegal;
                  nxt_st.rdata[STAT_OP_LSB +: 3]        = st_ff.op;
               end else if (st_ff.daddr == OFF_PSW) begin
                  nxt_st.rdata[PSW_W-1:0] = st_ff.flags;
               end else if (st_ff.daddr[11:7] == GPR_WIN_TAG) begin
                  rd_en          = 1'b1;
                  rd_addr        = st_ff.daddr[6:2];
                  nxt_st.rd_zero = (st_ff.daddr[6:2] == ZERO_REG);
                  nxt_st.fsm     = S_GPR;
               end
            end
         end
         S_RD_DST: begin
            rd_en          = 1'b1;
            rd_addr        = dst_idx;
            nxt_st.rd_zero = (dst_idx == ZERO_REG);
            nxt_st.fsm     = S_RD_SRC;
         end
         S_RD_SRC: begin
            nxt_st.opa     = rd_val;
            rd_en          = 1'b1;
            rd_addr        = src_idx;
            nxt_st.rd_zero = (src_idx == ZERO_REG);
            nxt_st.fsm     = S_EXEC;
         end
         S_EXEC: begin
            // Zero register stays zero even if software breaks the convention
            wr.en        = (dst_idx != ZERO_REG);
            wr.addr      = dst_idx;
            wr.data      = ex_res;
            nxt_st.flags = ex_flags;
            nxt_st.fsm   = S_IDLE;
         end
         S_GPR: begin
            nxt_st.rdata = rd_val;
            nxt_st.fsm   = S_RESP;
         end
         S_RESP: begin
            nxt_st.fsm = S_IDLE;
         end
         default: begin
            nxt_st.fsm = S_IDLE;
         end
      endcase
      if (hreadyout) begin
         nxt_st.dph   = accept;
         nxt_st.dwr   = hwrite;
         nxt_st.dok   = (hsize == SIZE_WORD);
         nxt_st.daddr = haddr[11:0];
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff         <= '0;
         st_ff.fsm     <= S_IDLE;
         st_ff.op      <= OP_NONE;
         st_ff.insn    <= INSN_RESET;
         st_ff.flags   <= flags_t'(PSW_RESET);
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign hresp  = 1'b0;
   assign hrdata = st_ff.rdata;

   // ==========================================================================
   // Assertions
   // ==========================================================================
   property p_sar_zero_keep;
      @(posedge hclk) disable iff (!hresetn)
      in_exec && st_ff.op == OP_SAR && cnt == 5'h00 |-> wr.data == dst_v ##1 !st_ff.flags.cy;
   endproperty
   a_sar_zero_keep: assert property (p_sar_zero_keep) else $error("zero shift changed data or carry");

   property p_sar_fill;
      @(posedge hclk) disable iff (!hresetn)
      in_exec && st_ff.op == OP_SAR |-> (wr.data[31] == dst_v[31]) &&
         (wr.data[0] == dst_v[cnt]) ##1 !st_ff.flags.ov && st_ff.flags.s == $past(dst_v[31]);
   endproperty
   a_sar_fill: assert property (p_sar_fill) else $error("arithmetic shift fill or flags wrong");

   property p_sar_carry;
      @(posedge hclk) disable iff (!hresetn)
      in_exec && st_ff.op == OP_SAR && cnt != 5'h00 |=> st_ff.flags.cy == $past(dst_v[5'(cnt - 5'h01)]);
   endproperty
   a_sar_carry: assert property (p_sar_carry) else $error("shift carry is not the last bit out");

   property p_sticky_hold;
      @(posedge hclk) disable iff (!hresetn)
      $fell(st_ff.flags.clamp_sticky_flag) |-> $past(psw_load);
   endproperty
   a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag cleared without a load");

   property p_ov_sets_sticky;
      @(posedge hclk) disable iff (!hresetn)
      in_exec && is_sub | (st_ff.op == OP_ADD) && ex_ov |=> st_ff.flags.clamp_sticky_flag && st_ff.flags.ov;
   endproperty
   a_ov_sets_sticky: assert property (p_ov_sets_sticky) else $error("overflow did not set sticky");

   property p_clamp_limits;
      @(posedge hclk) disable iff (!hresetn)
      in_exec && (st_ff.op == OP_ADD || is_sub) && ex_ov |->
         wr.data == (ex_a[31] ? 32'h8000_0000 : 32'h7fff_ffff);
   endproperty
   a_clamp_limits: assert property (p_clamp_limits) else $error("clamped value wrong");

   property p_shift_in_condition_keeps_flags;
      @(posedge hclk) disable iff (!hresetn)
      in_exec && st_ff.op == OP_SHIFT_IN_CONDITION |-> wr.data[31:1] == dst_v[30:0] ##1 st_ff.flags == $past(st_ff.flags);
   endproperty
   a_shift_in_condition_keeps_flags: assert property (p_shift_in_condition_keeps_flags) else $error("condition shift disturbed flags");

   property p_exec_timing;
      @(posedge hclk) disable iff (!hresetn)
      st_ff.fsm == S_IDLE && st_ff.dph && st_ff.dwr && st_ff.dok && st_ff.daddr == OFF_INSN &&
         decode_op(hwdata) != OP_NONE |=> ##2 in_exec ##1 st_ff.fsm == S_IDLE;
   endproperty
   a_exec_timing: assert property (p_exec_timing) else $error("write-back not three cycles after issue");

   property p_sub_borrow;
      @(posedge hclk) disable iff (!hresetn)
      in_exec && is_sub |=> st_ff.flags.cy == ($past(ex_a) < $past(ex_b));
   endproperty
   a_sub_borrow: assert property (p_sub_borrow) else $error("subtract borrow flag wrong");

endmodule // shift_saturate_alu
